// ===== include/vdec_ctrl_pkg.sv
/*
 * Constants for the decoder control register bank at subaddresses 00h to 08h:
 * offsets, reset values, writable-bit masks, field positions, mode codes and
 * the forced pixel values.
 * Assumes the serial host interface and the pixel datapath share one clock.
 */
// What this block does
// - Composite source bit picks input A or B
// - S-video: luma from A, chroma from B
// - Black output: luma 10h normal, 01h extended
// - Gain field: fixed, automatic, held; 10 reserved
// - TV/VCR field; in auto, unstable sync forces VCR, trap
// - Peak disable bits bypass peak processing
// - Freeze stops subcarrier loop; genlock shows increment
// - Power-down stops converters, minimises internal clocking
// - Pin 27 shows general-purpose value or blanking
// - Lock bit swaps PAL/field pins for locks
// - Pixel bus driven only with both enables
// - Sync enable tri-states sync pins; genlock always driven
// - Clock output enable, driven by default
// - Four masks exclude standards from autoswitching
// - Color killer mode: auto, forced, off
// - Killer threshold code maps -30 to -18 dB
// - Double-rate luma: whole frame or blanking only
// - Raw headers replaced by 40h when disabled
// - Signed luma delay from -8 to +7
// - Luma filter bit: comb or chroma trap
// - Peaking gain 0, 0.5, 1, 2 at 2.6 MHz
package vdec_ctrl_pkg;

	localparam logic [7:0] ADDR_SOURCE = 8'h00;
	localparam logic [7:0] ADDR_ANALOG = 8'h01;
	localparam logic [7:0] ADDR_MODE = 8'h02;
	localparam logic [7:0] ADDR_MISC = 8'h03;
	localparam logic [7:0] ADDR_STD_MASK = 8'h04;
	localparam logic [7:0] ADDR_KILL = 8'h06;
	localparam logic [7:0] ADDR_LUMA_A = 8'h07;
	localparam logic [7:0] ADDR_LUMA_B = 8'h08;

	localparam logic [7:0] RST_SOURCE = 8'h00;
	localparam logic [7:0] RST_ANALOG = 8'h15;
	localparam logic [7:0] RST_MODE = 8'h00;
	localparam logic [7:0] RST_MISC = 8'h01;
	localparam logic [7:0] RST_STD_MASK = 8'hdc;
	localparam logic [7:0] RST_KILL = 8'h10;
	localparam logic [7:0] RST_LUMA_A = 8'h60;
	localparam logic [7:0] RST_LUMA_B = 8'h00;

	// Bits a write may change; the rest keep their reset value
	localparam logic [7:0] WMASK_SOURCE = 8'h0b;
	localparam logic [7:0] WMASK_ANALOG = 8'h03;
	localparam logic [7:0] WMASK_MODE = 8'h7f;
	localparam logic [7:0] WMASK_MISC = 8'hff;
	localparam logic [7:0] WMASK_STD_MASK = 8'h3c;
	localparam logic [7:0] WMASK_KILL = 8'h7f;
	localparam logic [7:0] WMASK_LUMA_A = 8'hff;
	localparam logic [7:0] WMASK_LUMA_B = 8'h4f;

	localparam int SRC_SVIDEO = 0;
	localparam int SRC_INPUT_B = 1;
	localparam int SRC_BLACK = 3;
	localparam int MODE_POWER_DOWN = 0;
	localparam int MODE_LUMA_PEAK_OFF = 1;
	localparam int MODE_FREEZE = 2;
	localparam int MODE_COMP_PEAK_OFF = 3;
	localparam int MODE_TVVCR_LSB = 4;
	localparam int MISC_CLK_OE = 0;
	localparam int MISC_VBLANK_ON = 1;
	localparam int MISC_SYNC_OE = 2;
	localparam int MISC_DECODER_OE = 3;
	localparam int MISC_LOCK_SEL = 4;
	localparam int MISC_GP_OE = 5;
	localparam int MISC_GP_VALUE = 6;
	localparam int MISC_BLANK_SEL = 7;
	localparam int MASK_LSB = 2;
	localparam int KILL_MODE_LSB = 5;
	localparam int LUMA_A_BYPASS_VBLANK = 4;
	localparam int LUMA_A_RAW_HDR_OFF = 5;
	localparam int LUMA_A_DOUBLE_RATE = 7;
	localparam int LUMA_B_PEAK_LSB = 2;
	localparam int LUMA_B_TRAP = 6;
	localparam int CFG_GP_BLANK = 1;
	localparam int CFG_PAL_INDICATOR = 2;
	localparam int CFG_GENLOCK = 3;

	localparam logic [1:0] GAIN_FIXED = 2'b00;
	localparam logic [1:0] GAIN_AUTO = 2'b01;
	localparam logic [1:0] GAIN_RESERVED = 2'b10;
	localparam logic [1:0] GAIN_HOLD = 2'b11;
	localparam logic [1:0] TVVCR_AUTO = 2'b00;
	localparam logic [1:0] TVVCR_RESERVED = 2'b01;
	localparam logic [1:0] TVVCR_VCR = 2'b10;
	localparam logic [1:0] TVVCR_TV = 2'b11;
	localparam logic [1:0] KILL_AUTO = 2'b00;
	localparam logic [1:0] KILL_RESERVED = 2'b01;
	localparam logic [1:0] KILL_FORCED = 2'b10;
	localparam logic [1:0] KILL_OFF = 2'b11;

	localparam logic [7:0] BLACK_NORMAL = 8'h10;
	localparam logic [7:0] BLACK_EXTENDED = 8'h01;
	localparam logic [7:0] CHROMA_ZERO = 8'h80;
	localparam logic [7:0] DUMMY_HEADER = 8'h40;

	// Threshold in tenths of dB below reference; code 10000 lands on 240
	localparam logic [8:0] KILL_DB10_MAX = 9'h0b4;
	localparam logic [8:0] KILL_DB10_MID = 9'h0f0;
	localparam logic [4:0] KILL_CODE_MID = 5'h10;
	localparam logic [8:0] KILL_DB10_RESET = 9'h0f0;
	localparam logic [3:0] STD_MASK_RESET = 4'h7;

	localparam int PD_DIVIDE = 16;

endpackage

// ===== src/vdec_ctrl_regs.sv
/*
 * Control register bank of the video decoder (subaddresses 00h-08h) and the
 * logic it steers: input routing, gain and filter modes, subcarrier loop,
 * power-down clock enable, pixel output forcing and the shared output pins.
 * Assumes a host serial interface on CLK delivering one-cycle write and read
 * strobes, and decoder status inputs that are already on CLK.
 */
`timescale 1ns/10ps

module vdec_ctrl_regs #(
	parameter int INC_W = 24,
	parameter int PD_DIV = vdec_ctrl_pkg::PD_DIVIDE
) (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic [7:0] REG_ADDR,
	input wire logic REG_WE,
	input wire logic [7:0] REG_WDATA,
	input wire logic REG_RE,
	output logic [7:0] REG_RDATA,
	input wire logic [7:0] SHARED_PIN_CFG,
	input wire logic DATA_PROCESSOR_OUTPUT_ENABLE,
	input wire logic OUTPUT_RANGE_EXTENDED,
	input wire logic SYNC_UNSTABLE,
	input wire logic CHROMA_BELOW_THRESHOLD,
	input wire logic [INC_W-1:0] PHASE_INCREMENT,
	input wire logic GENLOCK_SERIAL,
	input wire logic HSYNC_IN,
	input wire logic VSYNC_IN,
	input wire logic PAL_INDICATOR,
	input wire logic FIELD_ID,
	input wire logic ACTIVE_VIDEO_FLAG,
	input wire logic VERTICAL_BLANKING_FLAG,
	input wire logic HORIZONTAL_LOCK_FLAG,
	input wire logic VERTICAL_LOCK_FLAG,
	input wire logic [7:0] PIXEL_IN,
	input wire logic PIXEL_IS_LUMA,
	input wire logic RAW_HEADER_SLOT,
	output logic LUMA_FROM_INPUT_B,
	output logic CHROMA_FROM_INPUT_B,
	output logic GAIN_AUTO,
	output logic GAIN_HOLD,
	output logic VCR_MODE,
	output logic COMB_ENABLE,
	output logic CHROMA_TRAP_ENABLE,
	output logic COMPOSITE_PEAK_ACTIVE,
	output logic LUMA_PEAK_ACTIVE,
	output logic [1:0] PEAKING_GAIN,
	output logic [INC_W-1:0] SUBCARRIER_PHASE,
	output logic [INC_W-1:0] GENLOCK_OUTPUT,
	output logic CONVERTER_ENABLE,
	output logic INTERNAL_CLK_EN,
	output logic [3:0] STANDARD_MASK,
	output logic COLOR_KILL_ACTIVE,
	output logic [8:0] KILL_THRESHOLD_DB10,
	output logic DOUBLE_RATE_LUMA,
	output logic [3:0] LUMA_DELAY,
	output logic [7:0] PIXEL_OUTPUT_BUS_O,
	output logic PIXEL_OUTPUT_BUS_OE_N,
	output logic HSYNC_PIN_O,
	output logic HSYNC_PIN_OE_N,
	output logic VSYNC_PAL_INDICATOR_PIN_O,
	output logic VSYNC_PAL_INDICATOR_PIN_OE_N,
	output logic FID_GENLOCK_OUTPUT_PIN_O,
	output logic FID_GENLOCK_OUTPUT_PIN_OE_N,
	output logic ACTIVE_VIDEO_FLAG_PIN_O,
	output logic ACTIVE_VIDEO_FLAG_PIN_OE_N,
	output logic GENERAL_PURPOSE_PIN_O,
	output logic GENERAL_PURPOSE_PIN_OE_N,
	output logic CLOCK_OUT_OE_N
);

	typedef struct packed {
		logic [7:0] source;
		logic [7:0] analog;
		logic [7:0] mode;
		logic [7:0] misc;
		logic [7:0] std_mask;
		logic [7:0] kill;
		logic [7:0] luma_a;
		logic [7:0] luma_b;
		logic [7:0] rdata;
		logic [INC_W-1:0] phase;
		logic [INC_W-1:0] genlock_output;
		logic [7:0] pd_cnt;
		logic clk_en;
		logic luma_b_src;
		logic chroma_b_src;
		logic gain_auto;
		logic gain_hold;
		logic vcr;
		logic comb_en;
		logic trap_en;
		logic cpeak;
		logic lpeak;
		logic [1:0] peak_gain;
		logic conv_en;
		logic [3:0] stdm;
		logic kill_on;
		logic [8:0] kill_db10;
		logic dbl_luma;
		logic [3:0] luma_dly;
		logic [7:0] pix;
		logic pix_oe_n;
		logic hs;
		logic hs_oe_n;
		logic p24;
		logic p24_oe_n;
		logic p23;
		logic p23_oe_n;
		logic active_video_flag;
		logic active_video_flag_oe_n;
		logic p27;
		logic p27_oe_n;
		logic clk_oe_n;
	} state_t;

	localparam state_t RESET_STATE = '{
		source: vdec_ctrl_pkg::RST_SOURCE,
		analog: vdec_ctrl_pkg::RST_ANALOG,
		mode: vdec_ctrl_pkg::RST_MODE,
		misc: vdec_ctrl_pkg::RST_MISC,
		std_mask: vdec_ctrl_pkg::RST_STD_MASK,
		kill: vdec_ctrl_pkg::RST_KILL,
		luma_a: vdec_ctrl_pkg::RST_LUMA_A,
		luma_b: vdec_ctrl_pkg::RST_LUMA_B,
		clk_en: 1'b1,
		gain_auto: 1'b1,
		comb_en: 1'b1,
		cpeak: 1'b1,
		lpeak: 1'b1,
		conv_en: 1'b1,
		stdm: vdec_ctrl_pkg::STD_MASK_RESET,
		kill_db10: vdec_ctrl_pkg::KILL_DB10_RESET,
		pix_oe_n: 1'b1,
		hs_oe_n: 1'b1,
		p24_oe_n: 1'b1,
		p23_oe_n: 1'b1,
		active_video_flag_oe_n: 1'b1,
		p27_oe_n: 1'b1,
		default: '0
	};

	localparam logic [7:0] PD_LAST = 8'(PD_DIV - 1);

	state_t q;
	state_t next_q;
	logic [1:0] tvvcr;
	logic [1:0] kmode;
	logic [4:0] kcode;
	logic [2:0] dmag;
	logic sync_oe;
	logic wr;

	always_comb
	begin
		next_q = q;
		wr = REG_WE;
		// Register writes: reserved bits keep reset value, reserved codes are dropped
		if (wr)
		begin
			case (REG_ADDR)
				vdec_ctrl_pkg::ADDR_SOURCE:
					next_q.source = (REG_WDATA & vdec_ctrl_pkg::WMASK_SOURCE)
						| (vdec_ctrl_pkg::RST_SOURCE & ~vdec_ctrl_pkg::WMASK_SOURCE);
				vdec_ctrl_pkg::ADDR_ANALOG:
					if (REG_WDATA[1:0] != vdec_ctrl_pkg::GAIN_RESERVED)
					begin
						next_q.analog = (REG_WDATA & vdec_ctrl_pkg::WMASK_ANALOG)
							| (vdec_ctrl_pkg::RST_ANALOG & ~vdec_ctrl_pkg::WMASK_ANALOG);
					end
				vdec_ctrl_pkg::ADDR_MODE:
				begin
					next_q.mode = REG_WDATA & vdec_ctrl_pkg::WMASK_MODE;
					if (REG_WDATA[vdec_ctrl_pkg::MODE_TVVCR_LSB +: 2] == vdec_ctrl_pkg::TVVCR_RESERVED)
					begin
						next_q.mode[vdec_ctrl_pkg::MODE_TVVCR_LSB +: 2] = q.mode[vdec_ctrl_pkg::MODE_TVVCR_LSB +: 2];
					end
				end
				vdec_ctrl_pkg::ADDR_MISC:
					next_q.misc = REG_WDATA & vdec_ctrl_pkg::WMASK_MISC;
				vdec_ctrl_pkg::ADDR_STD_MASK:
					next_q.std_mask = (REG_WDATA & vdec_ctrl_pkg::WMASK_STD_MASK)
						| (vdec_ctrl_pkg::RST_STD_MASK & ~vdec_ctrl_pkg::WMASK_STD_MASK);
				vdec_ctrl_pkg::ADDR_KILL:
				begin
					next_q.kill = REG_WDATA & vdec_ctrl_pkg::WMASK_KILL;
					if (REG_WDATA[vdec_ctrl_pkg::KILL_MODE_LSB +: 2] == vdec_ctrl_pkg::KILL_RESERVED)
					begin
						next_q.kill[vdec_ctrl_pkg::KILL_MODE_LSB +: 2] = q.kill[vdec_ctrl_pkg::KILL_MODE_LSB +: 2];
					end
				end
				vdec_ctrl_pkg::ADDR_LUMA_A:
					next_q.luma_a = REG_WDATA & vdec_ctrl_pkg::WMASK_LUMA_A;
				vdec_ctrl_pkg::ADDR_LUMA_B:
					next_q.luma_b = REG_WDATA & vdec_ctrl_pkg::WMASK_LUMA_B;
				default:
					next_q.rdata = q.rdata;
			endcase
		end
		// Read data holds until the next read strobe; unmapped subaddresses read 00h
		if (REG_RE)
		begin
			case (REG_ADDR)
				vdec_ctrl_pkg::ADDR_SOURCE: next_q.rdata = q.source;
				vdec_ctrl_pkg::ADDR_ANALOG: next_q.rdata = q.analog;
				vdec_ctrl_pkg::ADDR_MODE: next_q.rdata = q.mode;
				vdec_ctrl_pkg::ADDR_MISC: next_q.rdata = q.misc;
				vdec_ctrl_pkg::ADDR_STD_MASK: next_q.rdata = q.std_mask;
				vdec_ctrl_pkg::ADDR_KILL: next_q.rdata = q.kill;
				vdec_ctrl_pkg::ADDR_LUMA_A: next_q.rdata = q.luma_a;
				vdec_ctrl_pkg::ADDR_LUMA_B: next_q.rdata = q.luma_b;
				default: next_q.rdata = 8'h00;
			endcase
		end

		// Input routing; S-video ignores the channel-one bit
		next_q.chroma_b_src = q.source[vdec_ctrl_pkg::SRC_SVIDEO];
		next_q.luma_b_src = !q.source[vdec_ctrl_pkg::SRC_SVIDEO] && q.source[vdec_ctrl_pkg::SRC_INPUT_B];

		next_q.gain_auto = (q.analog[1:0] == vdec_ctrl_pkg::GAIN_AUTO);
		next_q.gain_hold = (q.analog[1:0] == vdec_ctrl_pkg::GAIN_HOLD);

		tvvcr = q.mode[vdec_ctrl_pkg::MODE_TVVCR_LSB +: 2];
		next_q.vcr = (tvvcr == vdec_ctrl_pkg::TVVCR_VCR)
			|| (tvvcr == vdec_ctrl_pkg::TVVCR_AUTO && SYNC_UNSTABLE);
		// VCR mode overrides the filter select bit
		next_q.comb_en = !next_q.vcr && !q.luma_b[vdec_ctrl_pkg::LUMA_B_TRAP];
		next_q.trap_en = next_q.vcr || q.luma_b[vdec_ctrl_pkg::LUMA_B_TRAP];

		next_q.cpeak = !q.mode[vdec_ctrl_pkg::MODE_COMP_PEAK_OFF];
		next_q.lpeak = !q.mode[vdec_ctrl_pkg::MODE_LUMA_PEAK_OFF];
		// Gain code goes straight to the 2.6 MHz peaking stage, forced 0 when bypassed
		next_q.peak_gain = next_q.lpeak ? q.luma_b[vdec_ctrl_pkg::LUMA_B_PEAK_LSB +: 2] : 2'b00;

		// Power-down keeps the loop ticking at a slow rate, not stopped
		next_q.conv_en = !q.mode[vdec_ctrl_pkg::MODE_POWER_DOWN];
		if (!q.mode[vdec_ctrl_pkg::MODE_POWER_DOWN])
		begin
			next_q.pd_cnt = 8'h00;
			next_q.clk_en = 1'b1;
		end
		else
		begin
			next_q.pd_cnt = (q.pd_cnt == PD_LAST) ? 8'h00 : q.pd_cnt + 8'h01;
			next_q.clk_en = (q.pd_cnt == PD_LAST);
		end

		if (!q.mode[vdec_ctrl_pkg::MODE_FREEZE])
		begin
			next_q.genlock_output = PHASE_INCREMENT;
			if (q.clk_en)
			begin
				next_q.phase = q.phase + q.genlock_output;
			end
		end

		next_q.stdm = q.std_mask[vdec_ctrl_pkg::MASK_LSB +: 4];

		kmode = q.kill[vdec_ctrl_pkg::KILL_MODE_LSB +: 2];
		next_q.kill_on = (kmode == vdec_ctrl_pkg::KILL_FORCED)
			|| (kmode == vdec_ctrl_pkg::KILL_AUTO && CHROMA_BELOW_THRESHOLD);
		// Two linear pieces so that 00000, 10000 and 11111 hit their exact figures
		kcode = q.kill[4:0];
		if (kcode <= vdec_ctrl_pkg::KILL_CODE_MID)
		begin
			next_q.kill_db10 = vdec_ctrl_pkg::KILL_DB10_MAX + 9'(({4'h0, kcode} * 9'd15) >> 2);
		end
		else
		begin
			next_q.kill_db10 = vdec_ctrl_pkg::KILL_DB10_MID + 9'({4'h0, kcode - vdec_ctrl_pkg::KILL_CODE_MID} << 2);
		end

		next_q.dbl_luma = q.luma_a[vdec_ctrl_pkg::LUMA_A_DOUBLE_RATE]
			|| (q.luma_a[vdec_ctrl_pkg::LUMA_A_BYPASS_VBLANK] && VERTICAL_BLANKING_FLAG);

		// Negative codes count down from 1000 = -1 to 1111 = -8
		dmag = q.luma_a[2:0];
		next_q.luma_dly = q.luma_a[3] ? 4'(4'h0 - ({1'b0, dmag} + 4'h1)) : {1'b0, dmag};

		// Pixel path: header substitution first, then black, then killed chroma
		if (RAW_HEADER_SLOT && q.luma_a[vdec_ctrl_pkg::LUMA_A_RAW_HDR_OFF])
		begin
			next_q.pix = vdec_ctrl_pkg::DUMMY_HEADER;
		end
		else if (q.source[vdec_ctrl_pkg::SRC_BLACK])
		begin
			if (PIXEL_IS_LUMA)
			begin
				next_q.pix = OUTPUT_RANGE_EXTENDED ? vdec_ctrl_pkg::BLACK_EXTENDED : vdec_ctrl_pkg::BLACK_NORMAL;
			end
			else
			begin
				next_q.pix = vdec_ctrl_pkg::CHROMA_ZERO;
			end
		end
		else if (!PIXEL_IS_LUMA && next_q.kill_on)
		begin
			next_q.pix = vdec_ctrl_pkg::CHROMA_ZERO;
		end
		else
		begin
			next_q.pix = PIXEL_IN;
		end
		next_q.pix_oe_n = !(q.misc[vdec_ctrl_pkg::MISC_DECODER_OE] && DATA_PROCESSOR_OUTPUT_ENABLE);

		// Sync pins; timing keeps running under black output
		sync_oe = q.misc[vdec_ctrl_pkg::MISC_SYNC_OE];
		next_q.hs = HSYNC_IN;
		next_q.hs_oe_n = !sync_oe;
		next_q.active_video_flag = ACTIVE_VIDEO_FLAG;
		next_q.active_video_flag_oe_n = !sync_oe;
		if (!SHARED_PIN_CFG[vdec_ctrl_pkg::CFG_PAL_INDICATOR])
		begin
			next_q.p24 = VSYNC_IN;
		end
		else
		begin
			next_q.p24 = q.misc[vdec_ctrl_pkg::MISC_LOCK_SEL] ? HORIZONTAL_LOCK_FLAG : PAL_INDICATOR;
		end
		next_q.p24_oe_n = !sync_oe;
		if (SHARED_PIN_CFG[vdec_ctrl_pkg::CFG_GENLOCK])
		begin
			next_q.p23 = GENLOCK_SERIAL;
			next_q.p23_oe_n = 1'b0;
		end
		else
		begin
			next_q.p23 = q.misc[vdec_ctrl_pkg::MISC_LOCK_SEL] ? VERTICAL_LOCK_FLAG : FIELD_ID;
			next_q.p23_oe_n = !sync_oe;
		end

		// Pin 27 belongs to the interrupt block unless the shared-pin bit hands it over
		if (!SHARED_PIN_CFG[vdec_ctrl_pkg::CFG_GP_BLANK])
		begin
			next_q.p27 = 1'b0;
			next_q.p27_oe_n = 1'b1;
		end
		else if (q.misc[vdec_ctrl_pkg::MISC_BLANK_SEL])
		begin
			next_q.p27 = VERTICAL_BLANKING_FLAG && q.misc[vdec_ctrl_pkg::MISC_VBLANK_ON];
			next_q.p27_oe_n = 1'b0;
		end
		else
		begin
			// Host must keep the enable set here, else the pin floats
			next_q.p27 = q.misc[vdec_ctrl_pkg::MISC_GP_VALUE];
			next_q.p27_oe_n = !q.misc[vdec_ctrl_pkg::MISC_GP_OE];
		end

		next_q.clk_oe_n = !q.misc[vdec_ctrl_pkg::MISC_CLK_OE];
	end

	always_ff @(posedge CLK)
	begin
		if (!RST_N)
		begin
			q <= RESET_STATE;
		end
		else
		begin
			q <= next_q;
		end
	end

	assign REG_RDATA = q.rdata;
	assign LUMA_FROM_INPUT_B = q.luma_b_src;
	assign CHROMA_FROM_INPUT_B = q.chroma_b_src;
	assign GAIN_AUTO = q.gain_auto;
	assign GAIN_HOLD = q.gain_hold;
	assign VCR_MODE = q.vcr;
	assign COMB_ENABLE = q.comb_en;
	assign CHROMA_TRAP_ENABLE = q.trap_en;
	assign COMPOSITE_PEAK_ACTIVE = q.cpeak;
	assign LUMA_PEAK_ACTIVE = q.lpeak;
	assign PEAKING_GAIN = q.peak_gain;
	assign SUBCARRIER_PHASE = q.phase;
	assign GENLOCK_OUTPUT = q.genlock_output;
	assign CONVERTER_ENABLE = q.conv_en;
	assign INTERNAL_CLK_EN = q.clk_en;
	assign STANDARD_MASK = q.stdm;
	assign COLOR_KILL_ACTIVE = q.kill_on;
	assign KILL_THRESHOLD_DB10 = q.kill_db10;
	assign DOUBLE_RATE_LUMA = q.dbl_luma;
	assign LUMA_DELAY = q.luma_dly;
	assign PIXEL_OUTPUT_BUS_O = q.pix;
	assign PIXEL_OUTPUT_BUS_OE_N = q.pix_oe_n;
	assign HSYNC_PIN_O = q.hs;
	assign HSYNC_PIN_OE_N = q.hs_oe_n;
	assign VSYNC_PAL_INDICATOR_PIN_O = q.p24;
	assign VSYNC_PAL_INDICATOR_PIN_OE_N = q.p24_oe_n;
	assign FID_GENLOCK_OUTPUT_PIN_O = q.p23;
	assign FID_GENLOCK_OUTPUT_PIN_OE_N = q.p23_oe_n;
	assign ACTIVE_VIDEO_FLAG_PIN_O = q.active_video_flag;
	assign ACTIVE_VIDEO_FLAG_PIN_OE_N = q.active_video_flag_oe_n;
	assign GENERAL_PURPOSE_PIN_O = q.p27;
	assign GENERAL_PURPOSE_PIN_OE_N = q.p27_oe_n;
	assign CLOCK_OUT_OE_N = q.clk_oe_n;

	AST_SVIDEO_ROUTE:
	assert property (@(posedge CLK) disable iff (!RST_N)
		q.source[vdec_ctrl_pkg::SRC_SVIDEO] |=> CHROMA_FROM_INPUT_B && !LUMA_FROM_INPUT_B)
		else $error("S-video routing wrong");

	AST_COMPOSITE_B:
	assert property (@(posedge CLK) disable iff (!RST_N)
		q.source[1:0] == 2'b10 |=> LUMA_FROM_INPUT_B)
		else $error("Composite input B not selected");

	AST_BLACK_LUMA:
	assert property (@(posedge CLK) disable iff (!RST_N)
		q.source[vdec_ctrl_pkg::SRC_BLACK] && PIXEL_IS_LUMA && !RAW_HEADER_SLOT && !OUTPUT_RANGE_EXTENDED
		|=> PIXEL_OUTPUT_BUS_O == vdec_ctrl_pkg::BLACK_NORMAL)
		else $error("Black luma level wrong");

	AST_VCR_TRAP:
	assert property (@(posedge CLK) disable iff (!RST_N)
		q.mode[5:4] == vdec_ctrl_pkg::TVVCR_AUTO && SYNC_UNSTABLE |=> VCR_MODE && CHROMA_TRAP_ENABLE && !COMB_ENABLE)
		else $error("Unstable sync did not force VCR mode");

	AST_FREEZE:
	assert property (@(posedge CLK) disable iff (!RST_N)
		q.mode[vdec_ctrl_pkg::MODE_FREEZE] && $past(q.mode[vdec_ctrl_pkg::MODE_FREEZE])
		|-> $stable(SUBCARRIER_PHASE) && $stable(GENLOCK_OUTPUT))
		else $error("Frozen subcarrier loop moved");

	AST_PD_RATE:
	assert property (@(posedge CLK) disable iff (!RST_N)
		q.mode[vdec_ctrl_pkg::MODE_POWER_DOWN] && INTERNAL_CLK_EN ##1 q.mode[vdec_ctrl_pkg::MODE_POWER_DOWN]
		|-> !INTERNAL_CLK_EN)
		else $error("Clock enable not reduced in power-down");

	AST_GP_PIN:
	assert property (@(posedge CLK) disable iff (!RST_N)
		SHARED_PIN_CFG[1] && !q.misc[7] && !q.misc[5] |=> GENERAL_PURPOSE_PIN_OE_N)
		else $error("General-purpose pin driven while disabled");

	AST_PIX_OE:
	assert property (@(posedge CLK) disable iff (!RST_N)
		!PIXEL_OUTPUT_BUS_OE_N |-> $past(q.misc[vdec_ctrl_pkg::MISC_DECODER_OE]) && $past(DATA_PROCESSOR_OUTPUT_ENABLE))
		else $error("Pixel bus driven without both enables");

	AST_GENLOCK_OUTPUT_DRIVEN:
	assert property (@(posedge CLK) disable iff (!RST_N)
		SHARED_PIN_CFG[vdec_ctrl_pkg::CFG_GENLOCK] |=> !FID_GENLOCK_OUTPUT_PIN_OE_N)
		else $error("Genlock pin not driven");

	AST_RAW_HEADER:
	assert property (@(posedge CLK) disable iff (!RST_N)
		RAW_HEADER_SLOT && q.luma_a[vdec_ctrl_pkg::LUMA_A_RAW_HDR_OFF] |=> PIXEL_OUTPUT_BUS_O == vdec_ctrl_pkg::DUMMY_HEADER)
		else $error("Dummy header not inserted");

endmodule // vdec_ctrl_regs

// ===== sim/host_model.sv
/*
 * Host controller model: one-cycle register write and read strobes.
 * Assumes the bank samples on the rising edge of CLK.
 */
`timescale 1ns/10ps
module host_model (
	input wire logic CLK,
	input wire logic [7:0] SHARED_PIN_CFG,
	input wire logic [7:0] REG_RDATA,
	output logic [7:0] REG_ADDR,
	output logic REG_WE,
	output logic [7:0] REG_WDATA,
	output logic REG_RE
);
	initial
	begin
		REG_ADDR = 8'h00;
		REG_WE = 1'b0;
		REG_WDATA = 8'h00;
		REG_RE = 1'b0;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] v;
		v = d;
		// Pin 27 in use: its enable must stay set
		if (a == 8'h03 && SHARED_PIN_CFG[1])
			v[5] = 1'b1;
		@(negedge CLK);
		REG_ADDR = a;
		REG_WDATA = v;
		REG_WE = 1'b1;
		@(negedge CLK);
		REG_WE = 1'b0;
		// Released data no longer shows the last value
		REG_WDATA = ~v;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge CLK);
		REG_ADDR = a;
		REG_RE = 1'b1;
		@(negedge CLK);
		REG_RE = 1'b0;
		@(negedge CLK);
		d = REG_RDATA;
	endtask
endmodule // host_model

// ===== sim/testbench.sv
/*
 * Self-checking bench for the decoder control bank.
 * Assumes host_model drives the register strobes.
 */
`timescale 1ns/10ps
module testbench;
	logic CLK, RST_N, REG_WE, REG_RE, PIXEL_IS_LUMA, RAW_HEADER_SLOT;
	logic [7:0] REG_ADDR, REG_WDATA, REG_RDATA, SHARED_PIN_CFG, PIXEL_IN, PIXEL_OUTPUT_BUS_O;
	logic DATA_PROCESSOR_OUTPUT_ENABLE, OUTPUT_RANGE_EXTENDED, SYNC_UNSTABLE, CHROMA_BELOW_THRESHOLD;
	logic [23:0] PHASE_INCREMENT, SUBCARRIER_PHASE, GENLOCK_OUTPUT;
	logic GENLOCK_SERIAL, HSYNC_IN, VSYNC_IN, PAL_INDICATOR, FIELD_ID, ACTIVE_VIDEO_FLAG;
	logic VERTICAL_BLANKING_FLAG, HORIZONTAL_LOCK_FLAG, VERTICAL_LOCK_FLAG;
	logic LUMA_FROM_INPUT_B, CHROMA_FROM_INPUT_B, GAIN_AUTO, GAIN_HOLD, VCR_MODE, COMB_ENABLE;
	logic CHROMA_TRAP_ENABLE, COMPOSITE_PEAK_ACTIVE, LUMA_PEAK_ACTIVE, CONVERTER_ENABLE, INTERNAL_CLK_EN;
	logic [1:0] PEAKING_GAIN;
	logic [3:0] STANDARD_MASK, LUMA_DELAY;
	logic [8:0] KILL_THRESHOLD_DB10;
	logic COLOR_KILL_ACTIVE, DOUBLE_RATE_LUMA, PIXEL_OUTPUT_BUS_OE_N, HSYNC_PIN_O, HSYNC_PIN_OE_N;
	logic VSYNC_PAL_INDICATOR_PIN_O, VSYNC_PAL_INDICATOR_PIN_OE_N, FID_GENLOCK_OUTPUT_PIN_O, FID_GENLOCK_OUTPUT_PIN_OE_N, ACTIVE_VIDEO_FLAG_PIN_O, ACTIVE_VIDEO_FLAG_PIN_OE_N;
	logic GENERAL_PURPOSE_PIN_O, GENERAL_PURPOSE_PIN_OE_N, CLOCK_OUT_OE_N;
	int n_errors, comparisons;
	logic [7:0] rv;
	logic [7:0] rst [9] = '{8'h00, 8'h15, 8'h00, 8'h01, 8'hdc, 8'h00, 8'h10, 8'h60, 8'h00};
	logic [7:0] wm [9] = '{8'h0b, 8'h03, 8'h7f, 8'hff, 8'h3c, 8'h00, 8'h7f, 8'hff, 8'h4f};

	// Short power-down divider keeps the pulse count quick to observe
	vdec_ctrl_regs #(.PD_DIV(2)) vdec_ctrl_regs_i (.*);
	host_model host_model_i (.*);

	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		comparisons++;
		if (g !== e)
		begin
			n_errors++;
			$display("[FAIL] t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic settle();
		repeat (3) @(negedge CLK);
	endtask
	task automatic wrap_up();
		$display("comparisons %0d errors %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic t_regs();
		for (int i = 0; i < 9; i++)
		begin
			host_model_i.rd(8'(i), rv);
			chk(rv, rst[i]);
			host_model_i.wr(8'(i), 8'hff);
			host_model_i.rd(8'(i), rv);
			chk(rv, rst[i] | wm[i]);
			host_model_i.wr(8'(i), 8'h00);
			host_model_i.rd(8'(i), rv);
			chk(rv, rst[i] & ~wm[i]);
		end
	endtask
	task automatic t_gain();
		logic [1:0] c [3] = '{2'b00, 2'b01, 2'b11};
		for (int i = 0; i < 3; i++)
		begin
			host_model_i.wr(8'h01, {6'h05, c[i]});
			settle();
			chk({6'h00, GAIN_HOLD, GAIN_AUTO}, {6'h00, c[i][1], c[i] == 2'b01});
		end
		// Reserved code must leave the held setting in place
		host_model_i.wr(8'h01, 8'h16);
		host_model_i.rd(8'h01, rv);
		chk(rv, 8'h17);
	endtask
	task automatic t_route();
		logic [7:0] s [4] = '{8'h00, 8'h02, 8'h01, 8'h03};
		logic [1:0] e [4] = '{2'b00, 2'b10, 2'b01, 2'b01};
		for (int i = 0; i < 4; i++)
		begin
			host_model_i.wr(8'h00, s[i]);
			settle();
			chk({6'h00, LUMA_FROM_INPUT_B, CHROMA_FROM_INPUT_B}, {6'h00, e[i]});
		end
	endtask
	task automatic t_pins();
		DATA_PROCESSOR_OUTPUT_ENABLE = 1'b1;
		HSYNC_IN = 1'b1;
		host_model_i.wr(8'h03, 8'h0c);
		settle();
		chk({4'h0, PIXEL_OUTPUT_BUS_OE_N, HSYNC_PIN_OE_N, HSYNC_PIN_O, CLOCK_OUT_OE_N}, 8'h03);
		DATA_PROCESSOR_OUTPUT_ENABLE = 1'b0;
		SHARED_PIN_CFG = 8'h02;
		host_model_i.wr(8'h03, 8'h61);
		settle();
		chk({4'h0, PIXEL_OUTPUT_BUS_OE_N, HSYNC_PIN_OE_N, GENERAL_PURPOSE_PIN_OE_N, CLOCK_OUT_OE_N}, 8'h0c);
		chk({7'h00, GENERAL_PURPOSE_PIN_O}, 8'h01);
		SHARED_PIN_CFG = 8'h00;
	endtask
	task automatic t_pixel();
		PIXEL_IN = 8'h55;
		PIXEL_IS_LUMA = 1'b1;
		host_model_i.wr(8'h00, 8'h08);
		settle();
		chk(PIXEL_OUTPUT_BUS_O, 8'h10);
		OUTPUT_RANGE_EXTENDED = 1'b1;
		settle();
		chk(PIXEL_OUTPUT_BUS_O, 8'h01);
		host_model_i.wr(8'h00, 8'h00);
		host_model_i.wr(8'h07, 8'h20);
		RAW_HEADER_SLOT = 1'b1;
		settle();
		chk(PIXEL_OUTPUT_BUS_O, 8'h40);
		host_model_i.wr(8'h07, 8'h00);
		settle();
		chk(PIXEL_OUTPUT_BUS_O, 8'h55);
		RAW_HEADER_SLOT = 1'b0;
		PIXEL_IS_LUMA = 1'b0;
		host_model_i.wr(8'h06, 8'h40);
		settle();
		chk(PIXEL_OUTPUT_BUS_O, 8'h80);
		host_model_i.wr(8'h06, 8'h60);
		settle();
		chk(PIXEL_OUTPUT_BUS_O, 8'h55);
	endtask
	task automatic t_mode();
		logic [7:0] m [3] = '{8'h20, 8'h30, 8'h00};
		logic [7:0] p;
		int n;
		SYNC_UNSTABLE = 1'b1;
		for (int i = 0; i < 3; i++)
		begin
			host_model_i.wr(8'h02, m[i]);
			settle();
			chk({5'h00, VCR_MODE, COMB_ENABLE, CHROMA_TRAP_ENABLE}, (i == 1) ? 8'h02 : 8'h05);
		end
		host_model_i.wr(8'h02, 8'h0e);
		settle();
		p = SUBCARRIER_PHASE[7:0];
		PHASE_INCREMENT = 24'h000020;
		settle();
		chk({6'h00, COMPOSITE_PEAK_ACTIVE, LUMA_PEAK_ACTIVE}, 8'h00);
		chk(SUBCARRIER_PHASE[7:0], p);
		chk(GENLOCK_OUTPUT[7:0], 8'h10);
		host_model_i.wr(8'h02, 8'h01);
		settle();
		n = 0;
		repeat (8) @(negedge CLK) n += int'(INTERNAL_CLK_EN);
		chk({7'h00, CONVERTER_ENABLE}, 8'h00);
		chk(8'(n), 8'h04);
		host_model_i.wr(8'h02, 8'h00);
		settle();
		chk({7'h00, CONVERTER_ENABLE}, 8'h01);
	endtask
	task automatic t_luma();
		SYNC_UNSTABLE = 1'b0;
		VERTICAL_BLANKING_FLAG = 1'b1;
		host_model_i.wr(8'h07, 8'h1f);
		host_model_i.wr(8'h08, 8'h4c);
		host_model_i.wr(8'h04, 8'h24);
		settle();
		chk({3'h0, DOUBLE_RATE_LUMA, LUMA_DELAY}, 8'h18);
		chk({3'h0, CHROMA_TRAP_ENABLE, COMB_ENABLE, 1'b0, PEAKING_GAIN}, 8'h13);
		chk({4'h0, STANDARD_MASK}, 8'h09);
		VERTICAL_BLANKING_FLAG = 1'b0;
		settle();
		chk({7'h00, DOUBLE_RATE_LUMA}, 8'h00);
		host_model_i.wr(8'h07, 8'h80);
		settle();
		chk({7'h00, DOUBLE_RATE_LUMA}, 8'h01);
	endtask
	task automatic t_misc();
		logic [23:0] p;
		// Unfrozen loop steps by the increment on every edge
		p = SUBCARRIER_PHASE;
		@(negedge CLK);
		chk(8'(SUBCARRIER_PHASE - p), 8'h20);
		chk(GENLOCK_OUTPUT[7:0], 8'h20);
		host_model_i.wr(8'h07, 8'h0b);
		CHROMA_BELOW_THRESHOLD = 1'b1;
		host_model_i.wr(8'h06, 8'h1f);
		settle();
		chk({4'h0, LUMA_DELAY}, 8'h0c);
		chk(KILL_THRESHOLD_DB10[8:1], 8'h96);
		chk({7'h00, COLOR_KILL_ACTIVE}, 8'h01);
		CHROMA_BELOW_THRESHOLD = 1'b0;
		host_model_i.wr(8'h06, 8'h00);
		settle();
		chk(KILL_THRESHOLD_DB10[8:1], 8'h5a);
		chk({7'h00, COLOR_KILL_ACTIVE}, 8'h00);
		{PAL_INDICATOR, VERTICAL_LOCK_FLAG, ACTIVE_VIDEO_FLAG, VERTICAL_BLANKING_FLAG, GENLOCK_SERIAL} = 5'h1f;
		SHARED_PIN_CFG = 8'h06;
		host_model_i.wr(8'h03, 8'h86);
		settle();
		chk({4'h0, VSYNC_PAL_INDICATOR_PIN_O, FID_GENLOCK_OUTPUT_PIN_O, ACTIVE_VIDEO_FLAG_PIN_O, GENERAL_PURPOSE_PIN_O}, 8'h0b);
		chk({4'h0, VSYNC_PAL_INDICATOR_PIN_OE_N, FID_GENLOCK_OUTPUT_PIN_OE_N, ACTIVE_VIDEO_FLAG_PIN_OE_N, GENERAL_PURPOSE_PIN_OE_N}, 8'h00);
		host_model_i.wr(8'h03, 8'hb6);
		settle();
		chk({4'h0, VSYNC_PAL_INDICATOR_PIN_O, FID_GENLOCK_OUTPUT_PIN_O, ACTIVE_VIDEO_FLAG_PIN_O, GENERAL_PURPOSE_PIN_O}, 8'h07);
		// Genlock selected: driven even with sync enable clear
		SHARED_PIN_CFG = 8'h0e;
		host_model_i.wr(8'h03, 8'h00);
		settle();
		chk({4'h0, VSYNC_PAL_INDICATOR_PIN_O, FID_GENLOCK_OUTPUT_PIN_O, ACTIVE_VIDEO_FLAG_PIN_O, GENERAL_PURPOSE_PIN_O}, 8'h0e);
		chk({4'h0, VSYNC_PAL_INDICATOR_PIN_OE_N, FID_GENLOCK_OUTPUT_PIN_OE_N, ACTIVE_VIDEO_FLAG_PIN_OE_N, GENERAL_PURPOSE_PIN_OE_N}, 8'h0a);
	endtask

	initial
	begin
		CLK = 1'b0;
		forever #5 CLK = ~CLK;
	end
	// A full run needs well under 2000 cycles
	initial
	begin
		#200000;
		n_errors++;
		wrap_up();
	end
	initial
	begin
		n_errors = 0;
		comparisons = 0;
		RST_N = 1'b0;
		{DATA_PROCESSOR_OUTPUT_ENABLE, OUTPUT_RANGE_EXTENDED, SYNC_UNSTABLE, CHROMA_BELOW_THRESHOLD} = '0;
		{GENLOCK_SERIAL, HSYNC_IN, VSYNC_IN, PAL_INDICATOR, FIELD_ID, ACTIVE_VIDEO_FLAG} = '0;
		{VERTICAL_BLANKING_FLAG, HORIZONTAL_LOCK_FLAG, VERTICAL_LOCK_FLAG, PIXEL_IS_LUMA, RAW_HEADER_SLOT} = '0;
		SHARED_PIN_CFG = 8'h00;
		PIXEL_IN = 8'h00;
		PHASE_INCREMENT = 24'h000010;
		repeat (16) @(negedge CLK);
		RST_N = 1'b1;
		t_regs();
		t_gain();
		t_route();
		t_pins();
		t_pixel();
		t_mode();
		t_luma();
		t_misc();
		wrap_up();
	end
endmodule // testbench
